// >>> rtl/iopc_route_mux.sv
// selects one remappable pin for a peripheral input, or ground
`timescale 1ns/1ps
`include "iopc_params.svh"
module iopc_route_mux #(
    parameter int N = `IOPC_RP_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [N-1:0] pins,
    input wire iopc_pkg::iopc_route_sel_t sel,
    output logic routed_q
);
    logic in_range;
    logic picked;

    // codes above the last pin, 11111 among them, tie the input low
    assign in_range = (32'(sel) < N);
    assign picked = in_range ? pins[sel] : 1'b0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            routed_q <= 1'b0;
        end else begin
            routed_q <= picked;
        end
    end
endmodule

// >>> rtl/iopc_sync.sv
// two-stage synchroniser for a group of levels
`timescale 1ns/1ps
module iopc_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // only the second stage is ever read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// >>> rtl/iopc_top.sv
// general-purpose i/o port with change notification and spi2 input routing
//
// What this block does
// - a set open-drain select bit makes the pin drive low only and float instead of driving high.
// - the analog pin configuration register resets to zero, so shared pins start in analog mode.
// - a port read returns 0 for every pin configured as analog, whatever its level.
// - a pin configured as digital input is cut off from the analog conversion path.
// - a level change on any enabled change-notice input raises an interrupt request.
// - change detection on enabled inputs keeps working with the clock stopped, via a wake output.
// - up to 21 change-notice inputs are supported.
// - each change-notice input has its own enable bit, split over a low and a high register.
// - each change-notice input has its own weak pull-up control bit, split over two registers.
// - bits 4 to 0 of the route register pick the remappable pin for the spi2 data, 11111 is ground.
`timescale 1ns/1ps
`include "iopc_params.svh"
module iopc_top #(
    parameter int PORT_W = `IOPC_PORT_W,
    parameter int CN_W = `IOPC_CN_W,
    parameter int RP_W = `IOPC_RP_W
) (
    input wire logic clk_sys,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // port pins
    input wire logic [PORT_W-1:0] pad_in,
    output logic [PORT_W-1:0] pad_out,
    output logic [PORT_W-1:0] pad_oe,
    output logic [PORT_W-1:0] analog_input_pin_connect,
    output logic [PORT_W-1:0] digital_in_enable,
    // change-notice pins
    input wire logic [CN_W-1:0] change_notice_input,
    output logic [CN_W-1:0] change_notice_pullup,
    output logic change_notice_wake,
    // remappable pins and spi2 inputs
    input wire logic [RP_W-1:0] remappable_pin,
    output logic spi2_serial_clock_in,
    output logic spi2_serial_data_in,
    output logic irq
);
    // =====================================================================
    // reset release
    logic rst_n;
    logic [0:0] rst_sync;

    iopc_sync #(.W(1)) u_rst_sync (
        .clk_sys(clk_sys),
        .rst_n(nrst),
        .d(1'b1),
        .q(rst_sync)
    );
    assign rst_n = rst_sync[0];

    // =====================================================================
    // registers
    logic [PORT_W-1:0] dir_q;
    logic [PORT_W-1:0] latch_q;
    logic [PORT_W-1:0] odsel_q;
    logic [PORT_W-1:0] ancfg_q;
    logic [CN_W-1:0] cn_en_q;
    logic [CN_W-1:0] pu_en_q;
    iopc_pkg::iopc_route_sel_t route_clk_q;
    iopc_pkg::iopc_route_sel_t route_dat_q;
    logic cn_pend_q;
    logic irq_en_q;

    // =====================================================================
    // bus address phase and data phase
    logic addr_ok;
    logic tr_active;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rd_data;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // seq is taken like nonseq: every access is a single word anyway
    assign tr_active = (htrans == 2'(iopc_pkg::IOPC_TR_NONSEQ)) || (htrans == 2'(iopc_pkg::IOPC_TR_SEQ));
    assign addr_ok = hsel && hready && tr_active;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            wr_addr_q <= haddr;
        end
    end

    logic wr_dir;
    logic wr_latch;
    logic wr_odsel;
    logic wr_ancfg;
    logic wr_cnen_lo;
    logic wr_cnen_hi;
    logic wr_pu_lo;
    logic wr_pu_hi;
    logic wr_route;
    logic wr_irq_clr;
    logic wr_irq_en;

    // a write to the port address lands in the output latch
    assign wr_dir = wr_pend_q && wr_addr_q == `IOPC_OFS_DIR;
    assign wr_latch = wr_pend_q && (wr_addr_q == `IOPC_OFS_LATCH || wr_addr_q == `IOPC_OFS_PORT);
    assign wr_odsel = wr_pend_q && wr_addr_q == `IOPC_OFS_ODSEL;
    assign wr_ancfg = wr_pend_q && wr_addr_q == `IOPC_OFS_ANCFG;
    assign wr_cnen_lo = wr_pend_q && wr_addr_q == `IOPC_OFS_CNEN_LO;
    assign wr_cnen_hi = wr_pend_q && wr_addr_q == `IOPC_OFS_CNEN_HI;
    assign wr_pu_lo = wr_pend_q && wr_addr_q == `IOPC_OFS_PU_LO;
    assign wr_pu_hi = wr_pend_q && wr_addr_q == `IOPC_OFS_PU_HI;
    assign wr_route = wr_pend_q && wr_addr_q == `IOPC_OFS_ROUTE;
    assign wr_irq_clr = wr_pend_q && wr_addr_q == `IOPC_OFS_IRQ_CLR;
    assign wr_irq_en = wr_pend_q && wr_addr_q == `IOPC_OFS_IRQ_EN;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // all pins come up as inputs, so nothing drives before software sets up
            dir_q <= `IOPC_RST_DIR;
            latch_q <= `IOPC_RST_LATCH;
            odsel_q <= `IOPC_RST_ODSEL;
            ancfg_q <= `IOPC_RST_ANCFG;
            irq_en_q <= `IOPC_RST_IRQ_EN;
        end else begin
            if (wr_dir) dir_q <= hwdata[PORT_W-1:0];
            if (wr_latch) latch_q <= hwdata[PORT_W-1:0];
            if (wr_odsel) odsel_q <= hwdata[PORT_W-1:0];
            if (wr_ancfg) ancfg_q <= hwdata[PORT_W-1:0];
            if (wr_irq_en) irq_en_q <= hwdata[`IOPC_IRQ_CN_BIT];
        end
    end

    // enables and pull-ups are split into a low and a high word
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cn_en_q <= `IOPC_RST_CNEN;
            pu_en_q <= `IOPC_RST_PU;
        end else begin
            if (wr_cnen_lo) cn_en_q[`IOPC_CN_LO_W-1:0] <= hwdata[`IOPC_CN_LO_W-1:0];
            if (wr_cnen_hi) cn_en_q[CN_W-1:`IOPC_CN_LO_W] <= hwdata[`IOPC_CN_HI_W-1:0];
            if (wr_pu_lo) pu_en_q[`IOPC_CN_LO_W-1:0] <= hwdata[`IOPC_CN_LO_W-1:0];
            if (wr_pu_hi) pu_en_q[CN_W-1:`IOPC_CN_LO_W] <= hwdata[`IOPC_CN_HI_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            route_clk_q <= `IOPC_RST_ROUTE_SEL;
            route_dat_q <= `IOPC_RST_ROUTE_SEL;
        end else if (wr_route) begin
            route_clk_q <= hwdata[`IOPC_ROUTE_CLK_LSB +: `IOPC_ROUTE_W];
            route_dat_q <= hwdata[`IOPC_ROUTE_DAT_LSB +: `IOPC_ROUTE_W];
        end
    end

    // =====================================================================
    // pin drivers
    // open drain only ever pulls low; a high latch bit floats the pin
    assign pad_out = latch_q & ~odsel_q;
    assign pad_oe = ~dir_q & ~(odsel_q & latch_q);
    // the analog path is connected only while a pin is in analog mode
    assign analog_input_pin_connect = ~ancfg_q;
    assign digital_in_enable = ancfg_q;
    assign change_notice_pullup = pu_en_q;
    // pull-ups are not forced off on outputs; keeping them off there is left to software

    // =====================================================================
    // input sampling
    logic [PORT_W-1:0] pad_s;
    logic [CN_W-1:0] cn_s;
    logic [RP_W-1:0] rp_s;
    logic [PORT_W-1:0] port_view;

    iopc_sync #(.W(PORT_W)) u_pad_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(pad_in),
        .q(pad_s)
    );
    iopc_sync #(.W(CN_W)) u_cn_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(change_notice_input),
        .q(cn_s)
    );
    iopc_sync #(.W(RP_W)) u_rp_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(remappable_pin),
        .q(rp_s)
    );

    // analog pins read back as low
    assign port_view = pad_s & ancfg_q;

    // =====================================================================
    // change notification
    logic [CN_W-1:0] cn_last_q;
    logic cn_changed;

    // all 21 inputs are compared against the level seen one cycle earlier
    // enables reset to zero, so the first captures after reset raise no false change
    assign cn_changed = |(cn_en_q & (cn_s ^ cn_last_q));
    // raw pins on purpose: with the clock stopped there is nothing to synchronise to,
    // so whoever uses this wake level must resynchronise it first
    assign change_notice_wake = |(cn_en_q & (change_notice_input ^ cn_last_q));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cn_last_q <= '0;
            cn_pend_q <= 1'b0;
        end else begin
            cn_last_q <= cn_s;
            // a new change in the clearing cycle keeps the flag set
            if (cn_changed) begin
                cn_pend_q <= 1'b1;
            end else if (wr_irq_clr && hwdata[`IOPC_IRQ_CN_BIT]) begin
                cn_pend_q <= 1'b0;
            end
        end
    end

    assign irq = cn_pend_q & irq_en_q;

    // =====================================================================
    // spi2 input routing
    // both routes pick from the same synchronised pins, so their delays match
    iopc_route_mux #(.N(RP_W)) u_route_clk (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pins(rp_s),
        .sel(route_clk_q),
        .routed_q(spi2_serial_clock_in)
    );
    iopc_route_mux #(.N(RP_W)) u_route_dat (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pins(rp_s),
        .sel(route_dat_q),
        .routed_q(spi2_serial_data_in)
    );

    // =====================================================================
    // read data
    // read data is fetched in the address phase, so a read right behind a
    // write to the same register sees the old value; software spaces them
    always_comb begin
        rd_data = 32'h0000_0000;
        if (haddr == `IOPC_OFS_DIR) begin
            rd_data[PORT_W-1:0] = dir_q;
        end else if (haddr == `IOPC_OFS_LATCH) begin
            rd_data[PORT_W-1:0] = latch_q;
        end else if (haddr == `IOPC_OFS_PORT) begin
            rd_data[PORT_W-1:0] = port_view;
        end else if (haddr == `IOPC_OFS_ODSEL) begin
            rd_data[PORT_W-1:0] = odsel_q;
        end else if (haddr == `IOPC_OFS_ANCFG) begin
            rd_data[PORT_W-1:0] = ancfg_q;
        end else if (haddr == `IOPC_OFS_CNEN_LO) begin
            rd_data[`IOPC_CN_LO_W-1:0] = cn_en_q[`IOPC_CN_LO_W-1:0];
        end else if (haddr == `IOPC_OFS_CNEN_HI) begin
            rd_data[`IOPC_CN_HI_W-1:0] = cn_en_q[CN_W-1:`IOPC_CN_LO_W];
        end else if (haddr == `IOPC_OFS_PU_LO) begin
            rd_data[`IOPC_CN_LO_W-1:0] = pu_en_q[`IOPC_CN_LO_W-1:0];
        end else if (haddr == `IOPC_OFS_PU_HI) begin
            rd_data[`IOPC_CN_HI_W-1:0] = pu_en_q[CN_W-1:`IOPC_CN_LO_W];
        end else if (haddr == `IOPC_OFS_ROUTE) begin
            rd_data[`IOPC_ROUTE_CLK_LSB +: `IOPC_ROUTE_W] = route_clk_q;
            rd_data[`IOPC_ROUTE_DAT_LSB +: `IOPC_ROUTE_W] = route_dat_q;
        end else if (haddr == `IOPC_OFS_IRQ_STAT) begin
            rd_data[`IOPC_IRQ_CN_BIT] = cn_pend_q;
        end else if (haddr == `IOPC_OFS_IRQ_EN) begin
            rd_data[`IOPC_IRQ_CN_BIT] = irq_en_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_data;
        end
    end

    // hsize is accepted but every access is treated as a whole word
    logic unused_ok;
    assign unused_ok = ^hsize;
endmodule

// >>> shared/iopc_params.svh
// register offsets, field positions, reset values and widths of the i/o port block
`ifndef IOPC_PARAMS_SVH
`define IOPC_PARAMS_SVH

// =====================================================================
// register byte offsets
`define IOPC_OFS_DIR        8'h00
`define IOPC_OFS_LATCH      8'h04
`define IOPC_OFS_PORT       8'h08
`define IOPC_OFS_ODSEL      8'h0c
`define IOPC_OFS_ANCFG      8'h10
`define IOPC_OFS_CNEN_LO    8'h14
`define IOPC_OFS_CNEN_HI    8'h18
`define IOPC_OFS_PU_LO      8'h1c
`define IOPC_OFS_PU_HI      8'h20
`define IOPC_OFS_ROUTE      8'h24
`define IOPC_OFS_IRQ_STAT   8'h28
`define IOPC_OFS_IRQ_CLR    8'h2c
`define IOPC_OFS_IRQ_EN     8'h30

// =====================================================================
// reset values
`define IOPC_RST_DIR        16'hffff
`define IOPC_RST_LATCH      16'h0000
`define IOPC_RST_ODSEL      16'h0000
`define IOPC_RST_ANCFG      16'h0000
`define IOPC_RST_CNEN       21'h000000
`define IOPC_RST_PU         21'h000000
`define IOPC_RST_ROUTE_SEL  5'h1f
`define IOPC_RST_IRQ_EN     1'h0

// =====================================================================
// field positions and sizes
`define IOPC_ROUTE_CLK_LSB  8
`define IOPC_ROUTE_DAT_LSB  0
`define IOPC_ROUTE_W        5
`define IOPC_CN_LO_W        16
`define IOPC_CN_HI_W        5
`define IOPC_IRQ_CN_BIT     0
`define IOPC_PORT_W         16
`define IOPC_CN_W           21
`define IOPC_RP_W           26

`endif

// >>> shared/iopc_pkg.sv
// shared types of the i/o port block
package iopc_pkg;

    // =====================================================================
    // bus transfer kinds
    typedef enum logic [1:0] {
        IOPC_TR_IDLE   = 2'b00,
        IOPC_TR_BUSY   = 2'b01,
        IOPC_TR_NONSEQ = 2'b10,
        IOPC_TR_SEQ    = 2'b11
    } iopc_htrans_t;

    typedef logic [4:0] iopc_route_sel_t;

endpackage

// >>> verif/iopc_pin_model.sv
// board-side model of the port pins
`timescale 1ns/1ps
module iopc_pin_model (
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe,
    input wire logic [15:0] ext_pad,
    input wire logic [20:0] cn_level,
    output logic [15:0] pad_in,
    output logic [20:0] change_notice_input
);
    // ==========================================================
    // pin levels
    // a released pin follows the board level, i.e. its external pull-up
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_pad);
    assign change_notice_input = cn_level;
endmodule

// >>> verif/iopc_top_chk.sv
// port-level assertions for iopc_top
`timescale 1ns/1ps
module iopc_top_chk #(
    parameter int PORT_W = 16,
    parameter int CN_W = 21,
    parameter int RP_W = 26
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [PORT_W-1:0] analog_input_pin_connect,
    input wire logic [PORT_W-1:0] digital_in_enable,
    input wire logic [CN_W-1:0] change_notice_input,
    input wire logic [CN_W-1:0] change_notice_pullup,
    input wire logic change_notice_wake,
    input wire logic [RP_W-1:0] remappable_pin,
    input wire logic spi2_serial_clock_in,
    input wire logic spi2_serial_data_in,
    input wire logic irq
);
    // ==========================================================
    // helper logic: which data phase is running
    wire logic take = hsel & hready & htrans[1];
    wire logic rp_any = |remappable_pin;
    logic wr_q;
    logic rd_port_q;
    logic rd_route_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_q <= 1'b0;
            rd_port_q <= 1'b0;
            rd_route_q <= 1'b0;
        end else begin
            wr_q <= take & hwrite;
            rd_port_q <= take & !hwrite & (haddr == 8'h08);
            rd_route_q <= take & !hwrite & (haddr == 8'h24);
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // assertions
    rst_vals_a: assert property ($rose(nrst) |-> &analog_input_pin_connect && !irq
        && !spi2_serial_clock_in && !spi2_serial_data_in) else $error("bad reset state");
    dig_cut_a: assert property (digital_in_enable == ~analog_input_pin_connect)
        else $error("digital input reaches analog path");
    port_analog_a: assert property (rd_port_q |-> hrdata[31:PORT_W] == '0
        && (hrdata[PORT_W-1:0] & $past(analog_input_pin_connect)) == '0) else $error("analog pin read as one");
    route_zero_a: assert property (rd_route_q |-> hrdata[31:13] == '0 && hrdata[7:5] == 3'h0)
        else $error("unused route bits set");
    spi_clk_a: assert property (spi2_serial_clock_in |-> $past(rp_any, 3)) else $error("clock from no pin");
    spi_dat_a: assert property (spi2_serial_data_in |-> $past(rp_any, 3)) else $error("data from no pin");
    pull_write_a: assert property ($changed(change_notice_pullup) |-> $past(wr_q))
        else $error("pull-up changed without write");
    irq_hold_a: assert property ($fell(irq) |-> $past(wr_q)) else $error("irq dropped unacknowledged");
    wake_settle_a: assert property ($stable(change_notice_input)[*6] |-> !change_notice_wake)
        else $error("wake stuck with quiet pins");
    ana_write_a: assert property ($changed(analog_input_pin_connect) |-> $past(wr_q))
        else $error("analog config changed without write");
endmodule
bind iopc_top iopc_top_chk #(.PORT_W(PORT_W), .CN_W(CN_W), .RP_W(RP_W)) iopc_top_chk_i (
    .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .analog_input_pin_connect(analog_input_pin_connect),
    .digital_in_enable(digital_in_enable), .change_notice_input(change_notice_input),
    .change_notice_pullup(change_notice_pullup), .change_notice_wake(change_notice_wake),
    .remappable_pin(remappable_pin), .spi2_serial_clock_in(spi2_serial_clock_in),
    .spi2_serial_data_in(spi2_serial_data_in), .irq(irq));

// >>> verif/tb.sv
// self-checking bench for iopc_top
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b1;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] ext_pad = 16'hffff;
    logic [20:0] cn_level = 21'h0;
    logic [25:0] rp_ext = 26'h0;
    logic [4:0] s;
    wire logic hready;
    wire logic [31:0] hrdata;
    wire logic [15:0] pad_in, pad_out, pad_oe, ana, dig;
    wire logic [20:0] cn_in, cn_pu;
    wire logic wake, sck, sdi, irq, hresp;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int codes[5] = '{0, 1, 25, 26, 31};
    always #10 clk_sys = ~clk_sys;
    iopc_top iopc_top_i (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .analog_input_pin_connect(ana),
        .digital_in_enable(dig), .change_notice_input(cn_in), .change_notice_pullup(cn_pu),
        .change_notice_wake(wake), .remappable_pin(rp_ext), .spi2_serial_clock_in(sck),
        .spi2_serial_data_in(sdi), .irq(irq));
    iopc_pin_model iopc_pin_model_i (.pad_out(pad_out), .pad_oe(pad_oe), .ext_pad(ext_pad),
        .cn_level(cn_level), .pad_in(pad_in), .change_notice_input(cn_in));
    // ==========================================================
    // bus tasks and comparison
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        chk(r, exp);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // a hang is cut short well above the expected run length
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            complete_run;
        end
    end
    // ==========================================================
    // test sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_chk(8'h00, 32'h0000ffff);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h24, 32'h00001f1f);
        wr(8'h3c, 32'hffffffff);
        rd_chk(8'h3c, 32'h0);
        chk(32'(hresp), 32'h0);
        rd_chk(8'h08, 32'h0);
        wr(8'h10, 32'h00ff);
        @(posedge clk_sys);
        rd_chk(8'h08, 32'h00ff);
        chk(32'(dig), 32'h00ff);
        chk(32'(ana), 32'hff00);
        // pull-ups stay off on the pins turned into outputs; analog pins stay inputs
        wr(8'h1c, 32'h0);
        wr(8'h04, 32'haaaa);
        wr(8'h0c, 32'h00ff);
        wr(8'h00, 32'hff00);
        // registers written at the last edge are only visible once that edge has settled
        @(negedge clk_sys);
        chk(32'(pad_oe), 32'h0055);
        chk(32'(pad_out), 32'haa00);
        repeat (3) @(posedge clk_sys);
        rd_chk(8'h08, 32'h00aa);
        wr(8'h1c, 32'h8001);
        wr(8'h20, 32'h10);
        @(negedge clk_sys);
        chk(32'(cn_pu), 32'h108001);
        @(posedge clk_sys);
        wr(8'h18, 32'h10);
        wr(8'h30, 32'h1);
        cn_level[3] <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk(32'(irq), 32'h0);
        cn_level[20] <= 1'b1;
        @(negedge clk_sys);
        chk(32'(wake), 32'h1);
        repeat (5) @(posedge clk_sys);
        chk(32'(irq), 32'h1);
        repeat (10) @(posedge clk_sys);
        chk(32'(irq), 32'h1);
        wr(8'h30, 32'h0);
        @(posedge clk_sys);
        chk(32'(irq), 32'h0);
        rd_chk(8'h28, 32'h1);
        wr(8'h2c, 32'h1);
        repeat (2) @(posedge clk_sys);
        rd_chk(8'h28, 32'h0);
        wr(8'h30, 32'h1);
        cn_level[20] <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk(32'(irq), 32'h1);
        wr(8'h2c, 32'h1);
        for (int k = 0; k < 10; k++) begin
            s = 5'(codes[k % 5]);
            rp_ext <= (s < 26) ? (26'h1 << s) : 26'h3ffffff;
            if (k < 5)
                wr(8'h24, {19'h0, s, 3'h0, s ^ 5'h01});
            else
                wr(8'h24, {19'h0, s ^ 5'h01, 3'h0, s});
            repeat (5) @(posedge clk_sys);
            chk(32'({sck, sdi}), (s < 26) ? ((k < 5) ? 32'h2 : 32'h1) : 32'h0);
        end
        wr(8'h24, 32'hffffffff);
        rd_chk(8'h24, 32'h00001f1f);
        complete_run;
    end
endmodule
